// ---- verification/tciu_core_model.sv ----
// Purpose: Core that acknowledges vectored requests
// Assumes: One-cycle ack, then gap+1 idle cycles
// Notes: A gap of 0 still leaves one idle cycle between acks
`timescale 1ns/1ns
module tciu_core_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic core_req,
    input wire logic [3:0] core_vector,
    input wire logic [7:0] gap,
    output logic core_ack,
    output logic [3:0] last_vec,
    output logic [15:0] n_acks
);
    logic [7:0] wait_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_ack <= 1'b0;
            last_vec <= 4'h0;
            n_acks <= 16'h0;
            wait_cnt <= 8'h0;
        end else if (core_ack) begin
            core_ack <= 1'b0;
            last_vec <= core_vector;
            n_acks <= n_acks + 16'h1;
            wait_cnt <= gap;
        end else if (wait_cnt != 8'h0) begin
            wait_cnt <= wait_cnt - 8'h1;
        end else if (core_req) begin
            core_ack <= 1'b1;
        end
    end
endmodule

// ---- verification/tciu_props.sv ----
// Purpose: Port assertions for tciu_top
// Assumes: Mask and control bits mirrored from completed APB writes
// Notes: Bind follows the module
`timescale 1ns/1ns
module tciu_props #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic bus_reset_req,
    input wire logic [2:0] ep_done,
    input wire logic wake_req,
    input wire logic serial_activity,
    input wire logic core_ack,
    input wire logic core_req,
    input wire logic [3:0] core_vector,
    input wire logic irq
);
    logic [9:0] shadow_mask;
    logic [3:0] shadow_ctrl;
    logic wr;
    assign wr = psel && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shadow_mask <= 10'h000;
            shadow_ctrl <= 4'h0;
        end else if (wr && paddr == tciu_pkg::OFS_MASK) begin
            shadow_mask <= pwdata[9:0];
        end else if (wr && paddr == tciu_pkg::OFS_CTRL) begin
            shadow_ctrl <= pwdata[3:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Bus cycles excluded except in the idle and range checks: a mask write or status read may drop irq legally
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    property p_ep; !psel && |(ep_done & shadow_mask[5:3]) |=> irq; endproperty
    a_ep: assert property (p_ep) else $error("endpoint event lost");
    property p_src; !psel && (bus_reset_req && shadow_mask[0] || wake_req && shadow_mask[8])
        |=> irq; endproperty
    a_src: assert property (p_src) else $error("source event lost");
    property p_ps2; !psel && serial_activity && shadow_ctrl[3] && shadow_mask[0] |=> irq;
    endproperty
    a_ps2: assert property (p_ps2) else $error("line activity lost");
    property p_req; !psel && !$past(psel) |-> core_req == (shadow_ctrl[0] && irq); endproperty
    a_req: assert property (p_req) else $error("core_req not gated");
    property p_idle; !irq |-> !core_req && core_vector == 4'h0; endproperty
    a_idle: assert property (p_idle) else $error("vector without irq");
    property p_vec; core_vector <= 4'h9; endproperty
    a_vec: assert property (p_vec) else $error("vector out of range");
    property p_fall; $fell(irq) |-> $past(core_ack) || $past(psel); endproperty
    a_fall: assert property (p_fall) else $error("irq dropped alone");
    property p_hold; irq && !core_ack && !psel |=> irq; endproperty
    a_hold: assert property (p_hold) else $error("pending not held");
endmodule
bind tciu_top tciu_props #(.ADDR_W(ADDR_W)) u_props (.pclk, .presetn, .psel, .pwrite,
    .paddr, .pwdata, .pready, .bus_reset_req, .ep_done, .wake_req, .serial_activity,
    .core_ack, .core_req, .core_vector, .irq);

// ---- verification/tciu_top_bench.sv ----
// Purpose: Directed test of tciu_top over APB and the core handshake
// Assumes: Core model acks every request
// Notes: Tap phase dominates run time
`timescale 1ns/1ns
module tciu_top_bench;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [7:0] pins = 8'h00;
    logic [5:0] ev = 6'h00;
    logic [7:0] gap = 8'h02;
    logic [31:0] prdata, q;
    logic pready, pslverr, core_ack, core_req, irq;
    logic se;
    logic [3:0] core_vector, last_vec;
    logic [3:0] vecs [5] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h8};
    logic [15:0] n_acks;
    logic [11:0] t;
    int n_fail = 0;
    int comparisons = 0;
    int cyc;
    always #5 pclk = ~pclk;
    tciu_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .port_pins(pins), .bus_reset_req(ev[0]), .ep_done(ev[3:1]),
        .wake_req(ev[4]), .serial_activity(ev[5]), .core_ack, .core_req, .core_vector, .irq);
    tciu_core_model u_core (.pclk, .presetn, .core_req, .core_vector, .gap, .core_ack,
        .last_vec, .n_acks);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic results();
        if (n_fail == 0 && comparisons > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        q = prdata;
        se = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            n_fail++;
            results();
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check("prdata", q, exp);
    endtask
    task automatic fire(input logic [5:0] v);
        @(posedge pclk);
        ev <= v;
        @(posedge pclk);
        ev <= 6'h00;
    endtask
    task automatic take(input logic [3:0] exp);
        logic [15:0] n0;
        n0 = n_acks;
        cyc = 0;
        while (n_acks === n0 && cyc < 14000) begin
            @(posedge pclk);
            cyc++;
        end
        if (n_acks === n0) begin
            n_fail++;
            results();
        end
        check("vector", {28'h0, last_vec}, {28'h0, exp});
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(tciu_pkg::OFS_TIMER, 32'h0);
        rd(tciu_pkg::OFS_CAPTURE, 32'h0);
        apb(1'b0, 8'h1c, 32'h0);
        check("pslverr", {31'h0, se}, 32'h1);
        apb(1'b1, tciu_pkg::OFS_MASK, 32'h3ff);
        apb(1'b1, tciu_pkg::OFS_CTRL, 32'h1);
        for (int k = 0; k < 5; k++) begin
            fire(6'(1 << k));
            take(vecs[k]);
        end
        gap <= 8'h14;
        fire(6'h18);
        take(4'h5);
        take(4'h8);
        gap <= 8'h02;
        apb(1'b1, tciu_pkg::OFS_MASK, 32'h0);
        fire(6'h01);
        check("irq", {31'h0, irq}, 32'h0);
        rd(tciu_pkg::OFS_STATUS, 32'h1);
        rd(tciu_pkg::OFS_STATUS, 32'h0);
        apb(1'b1, tciu_pkg::OFS_MASK, 32'h3ff);
        fire(6'h20);
        rd(tciu_pkg::OFS_STATUS, 32'h0);
        apb(1'b1, tciu_pkg::OFS_CTRL, 32'h9);
        fire(6'h20);
        take(4'h0);
        apb(1'b1, tciu_pkg::OFS_PORT_CFG, 32'h8);
        pins <= 8'h0c;
        rd(tciu_pkg::OFS_STATUS, 32'h0);
        pins <= 8'h00;
        take(4'h9);
        apb(1'b1, tciu_pkg::OFS_PORT_CFG, 32'h808);
        pins <= 8'h08;
        take(4'h9);
        apb(1'b1, tciu_pkg::OFS_CTRL, 32'h101);
        apb(1'b0, tciu_pkg::OFS_TIMER, 32'h0);
        t = q[11:0];
        pins <= 8'h01;
        take(4'h6);
        apb(1'b0, tciu_pkg::OFS_CAPTURE, 32'h0);
        check("cap_a", {31'h0, (q[7:0] - t[7:0]) < 8'h02}, 32'h1);
        apb(1'b1, tciu_pkg::OFS_CTRL, 32'h841);
        apb(1'b0, tciu_pkg::OFS_TIMER, 32'h0);
        t = q[11:0];
        pins <= 8'h03;
        rd(tciu_pkg::OFS_STATUS, 32'h0);
        pins <= 8'h01;
        take(4'h7);
        apb(1'b0, tciu_pkg::OFS_CAPTURE, 32'h0);
        check("cap_b", {31'h0, (q[31:24] - t[11:4]) < 8'h02}, 32'h1);
        check("cap_mid", {16'h0, q[23:8]}, 32'h0);
        apb(1'b1, tciu_pkg::OFS_CTRL, 32'h3);
        take(4'h1);
        take(4'h1);
        check("period", {31'h0, cyc > 12790 && cyc < 12810}, 32'h1);
        apb(1'b1, tciu_pkg::OFS_CTRL, 32'h1);
        repeat (13000) @(posedge pclk);
        rd(tciu_pkg::OFS_STATUS, 32'h0);
        results();
    end
endmodule

// ---- verilog/tciu_pkg.sv ----
// Purpose: Shared constants and state layout of the timer/capture interrupt unit
// Assumes: 100 MHz pclk, APB register access, 32-bit data
// Notes: All offsets are byte addresses of aligned words
package tciu_pkg;

    localparam int unsigned CLK_PERIOD_NS = 10;
    localparam int unsigned TICK_PERIOD_NS = 1000;
    localparam int unsigned TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam int unsigned DIV_W = $clog2(TICK_CYCLES);

    localparam int unsigned TIMER_W = 12;
    localparam int unsigned TAP_FAST_US = 128;
    localparam int unsigned TAP_SLOW_NS = 1024000;
    localparam int unsigned TAP_FAST_BITS = $clog2(TAP_FAST_US * 1000 / TICK_PERIOD_NS);
    localparam int unsigned TAP_SLOW_BITS = $clog2(TAP_SLOW_NS / TICK_PERIOD_NS);

    localparam int unsigned NUM_SRC = 10;
    localparam int unsigned SRC_BUS_RESET = 0;
    localparam int unsigned SRC_TAP_FAST = 1;
    localparam int unsigned SRC_TAP_SLOW = 2;
    localparam int unsigned SRC_EP0 = 3;
    localparam int unsigned SRC_CAP_A = 6;
    localparam int unsigned SRC_CAP_B = 7;
    localparam int unsigned SRC_WAKE = 8;
    localparam int unsigned SRC_PORT = 9;

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_TIMER = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_MASK = 8'h0c;
    localparam logic [7:0] OFS_CAPTURE = 8'h10;
    localparam logic [7:0] OFS_PORT_CFG = 8'h14;
    localparam logic [7:0] OFS_VECTOR = 8'h18;

    localparam int unsigned CTRL_W = 12;
    localparam int unsigned CTRL_GIE = 0;
    localparam int unsigned CTRL_TAP_FAST_EN = 1;
    localparam int unsigned CTRL_TAP_SLOW_EN = 2;
    localparam int unsigned CTRL_PS2_MODE = 3;
    localparam int unsigned CTRL_PRESCALE_LSB = 4;
    localparam int unsigned CTRL_CAP_EN_LSB = 8;
    localparam logic [2:0] PRESCALE_MAX = 3'h4;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 12'h000;
    localparam logic [NUM_SRC-1:0] MASK_RESET = 10'h000;

    typedef struct packed {
        logic [DIV_W-1:0] div;
        logic [TIMER_W-1:0] timer;
        logic [CTRL_W-1:0] ctrl;
        logic [NUM_SRC-1:0] pend;
        logic [NUM_SRC-1:0] mask;
        logic [7:0] port_mask;
        logic [7:0] port_pol;
        logic [7:0] pin_q;
        logic [3:0][7:0] cap;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
        logic core_req;
        logic [3:0] core_vector;
    } tciu_state_s;

endpackage

// ---- verilog/tciu_top.sv ----
// Purpose: Vectored interrupt controller with free-running timer, edge capture
//          and port-pin interrupts, reached over APB
// Assumes: All inputs synchronous to pclk; request inputs are high for the event
// Notes: Pending bits clear on core acknowledge or on a status read
`timescale 1ns/1ns

module tciu_top #(
    parameter int unsigned ADDR_W = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] port_pins,
    input wire logic bus_reset_req,
    input wire logic [2:0] ep_done,
    input wire logic wake_req,
    input wire logic serial_activity,
    input wire logic core_ack,
    output logic core_req,
    output logic [3:0] core_vector,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Eight-bit window of the counter, shifted up by the prescale setting
    function automatic logic [7:0] cap_slice(
        input logic [tciu_pkg::TIMER_W-1:0] t,
        input logic [2:0] sel
    );
        logic [2:0] s;
        s = (sel > tciu_pkg::PRESCALE_MAX) ? tciu_pkg::PRESCALE_MAX : sel;
        cap_slice = 8'(t >> s);
    endfunction

    // Lowest index wins: bus reset is the most urgent source
    function automatic logic [3:0] first_set(input logic [tciu_pkg::NUM_SRC-1:0] v);
        first_set = 4'h0;
        for (int i = tciu_pkg::NUM_SRC - 1; i >= 0; i--) begin
            if (v[i]) begin
                first_set = 4'(i);
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // State

    tciu_pkg::tciu_state_s s;
    tciu_pkg::tciu_state_s next_s;

    logic capture_pin_a;
    logic capture_pin_b;
    logic tick;
    logic access;
    logic done;
    logic hit;
    logic [tciu_pkg::NUM_SRC-1:0] ev;
    logic [tciu_pkg::NUM_SRC-1:0] clr;
    logic [7:0] rise;
    logic [7:0] fall;
    logic [7:0] slice;
    logic [3:0] cap_hit;
    logic [31:0] rd;

    assign capture_pin_a = port_pins[0];
    assign capture_pin_b = port_pins[1];

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        next_s = s;
        ev = '0;
        clr = '0;
        rd = 32'h0000_0000;
        hit = 1'b1;

        // Time base and free-running counter
        tick = (s.div == tciu_pkg::DIV_W'(tciu_pkg::TICK_CYCLES - 1));
        next_s.div = tick ? '0 : s.div + 1'b1;
        if (tick) begin
            next_s.timer = s.timer + 1'b1;
        end

        // Taps fire as the low counter bits roll over
        ev[tciu_pkg::SRC_TAP_FAST] = tick & s.ctrl[tciu_pkg::CTRL_TAP_FAST_EN]
            & (&s.timer[tciu_pkg::TAP_FAST_BITS-1:0]);
        ev[tciu_pkg::SRC_TAP_SLOW] = tick & s.ctrl[tciu_pkg::CTRL_TAP_SLOW_EN]
            & (&s.timer[tciu_pkg::TAP_SLOW_BITS-1:0]);

        // Plain request inputs; serial activity shares the bus-reset vector
        ev[tciu_pkg::SRC_BUS_RESET] = bus_reset_req
            | (serial_activity & s.ctrl[tciu_pkg::CTRL_PS2_MODE]);
        ev[tciu_pkg::SRC_EP0 +: 3] = ep_done;
        ev[tciu_pkg::SRC_WAKE] = wake_req;

        // Edge detection on the port
        rise = port_pins & ~s.pin_q;
        fall = ~port_pins & s.pin_q;
        next_s.pin_q = port_pins;

        // Capture: index 0 A rise, 1 A fall, 2 B rise, 3 B fall
        slice = cap_slice(s.timer, s.ctrl[tciu_pkg::CTRL_PRESCALE_LSB +: 3]);
        cap_hit = {fall[1], rise[1], fall[0], rise[0]}
            & s.ctrl[tciu_pkg::CTRL_CAP_EN_LSB +: 4];
        for (int i = 0; i < 4; i++) begin
            if (cap_hit[i]) begin
                next_s.cap[i] = slice;
            end
        end
        ev[tciu_pkg::SRC_CAP_A] = |cap_hit[1:0];
        ev[tciu_pkg::SRC_CAP_B] = |cap_hit[3:2];

        // Port interrupt: masked, per-pin polarity, one shared source
        ev[tciu_pkg::SRC_PORT] = |(s.port_mask
            & ((s.port_pol & rise) | (~s.port_pol & fall)));

        // APB: one wait cycle, then a registered answer
        access = psel & penable;
        done = access & s.pready;
        next_s.pready = access & ~s.pready;
        unique case (8'(paddr))
            tciu_pkg::OFS_CTRL: rd = 32'(s.ctrl);
            tciu_pkg::OFS_TIMER: rd = 32'(s.timer);
            tciu_pkg::OFS_STATUS: rd = 32'(s.pend);
            tciu_pkg::OFS_MASK: rd = 32'(s.mask);
            tciu_pkg::OFS_CAPTURE: rd = s.cap;
            tciu_pkg::OFS_PORT_CFG: rd = {16'h0000, s.port_pol, s.port_mask};
            tciu_pkg::OFS_VECTOR: rd = {27'h0, s.core_req, s.core_vector};
            default: hit = 1'b0;
        endcase
        if (access & ~s.pready) begin
            next_s.prdata = pwrite ? 32'h0000_0000 : rd;
            next_s.pslverr = ~hit;
        end else begin
            next_s.prdata = 32'h0000_0000;
            next_s.pslverr = 1'b0;
        end

        // Writes take effect at the completing edge; read-only words ignore them
        if (done & pwrite) begin
            unique case (8'(paddr))
                tciu_pkg::OFS_CTRL: next_s.ctrl = pwdata[tciu_pkg::CTRL_W-1:0];
                tciu_pkg::OFS_MASK: next_s.mask = pwdata[tciu_pkg::NUM_SRC-1:0];
                tciu_pkg::OFS_PORT_CFG: begin
                    next_s.port_mask = pwdata[7:0];
                    next_s.port_pol = pwdata[15:8];
                end
                default: ;
            endcase
        end

        // Pending: cleared by status read or acknowledge, an event the same cycle wins
        if (done & ~pwrite & (8'(paddr) == tciu_pkg::OFS_STATUS)) begin
            clr = '1;
        end
        if (core_ack & s.core_req) begin
            clr[s.core_vector] = 1'b1;
        end
        next_s.pend = (s.pend & ~clr) | ev;

        // Vector and interrupt line follow the new pending and mask values
        next_s.irq = |(next_s.pend & next_s.mask);
        next_s.core_req = next_s.ctrl[tciu_pkg::CTRL_GIE] & next_s.irq;
        next_s.core_vector = first_set(next_s.pend & next_s.mask);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '{ctrl: tciu_pkg::CTRL_RESET, mask: tciu_pkg::MASK_RESET, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign prdata = s.prdata;
    assign pready = s.pready;
    assign pslverr = s.pslverr;
    assign irq = s.irq;
    assign core_req = s.core_req;
    assign core_vector = s.core_vector;

endmodule
